/* verilog/fsc_pkg.sv */
package fsc_pkg;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFF_STATE_LO = 8'h00;
  localparam logic [7:0] OFF_STATE_HI = 8'h04;
  localparam logic [7:0] OFF_DIRTY = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // ----------------------------------------
  // state register fields
  // ----------------------------------------
  localparam int CEXC_LSB = 0;
  localparam int AEXC_LSB = 5;
  localparam int CC0_LSB = 10;
  localparam int QNE_BIT = 13;
  localparam int FTT_LSB = 14;
  localparam int VER_LSB = 17;
  localparam int NONSTD_BIT = 22;
  localparam int TEM_LSB = 23;
  localparam int RD_LSB = 30;
  localparam int CC1_LSB = 32;
  localparam int CC2_LSB = 34;
  localparam int CC3_LSB = 36;
  localparam logic [63:0] STATE_WR_MASK = 64'h0000_003F_CF80_0FFF;
  localparam logic [63:0] STATE_RD_MASK = 64'h0000_003F_CF8F_EFFF;
  localparam logic [63:0] STATE_RESET = 64'h0000_0000_0000_0000;

  // exception bit order: invalid, overflow, underflow, div-zero, inexact
  localparam int EXC_UF = 2;
  localparam int EXC_NX = 0;

  localparam logic [2:0] FTT_NONE = 3'h0;
  localparam logic [2:0] FTT_IEEE = 3'h1;
  localparam logic [2:0] FTT_UNIMPL = 3'h3;

  localparam logic [1:0] RD_NEAREST = 2'h0;
  localparam logic [1:0] RD_ZERO = 2'h1;
  localparam logic [1:0] RD_PLUS_INF = 2'h2;
  localparam logic [1:0] RD_MINUS_INF = 2'h3;

  // ----------------------------------------
  // interrupt events, fp_regfile_state_reg layout, bus answers
  // ----------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_IEEE = 0;
  localparam int IRQ_OTHER = 1;
  localparam int IRQ_LDFSR = 2;
  localparam int DIRTY_LO_BIT = 0;
  localparam int DIRTY_HI_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FSC_RUN = 2'b01,
    FSC_TRAP = 2'b10
  } fsc_state_t;

endpackage

/* verilog/fsc_exc_eval.sv */
`timescale 1ns/1ps
module fsc_exc_eval (
  input wire logic [4:0] tem,
  input wire logic [4:0] raw_exc,
  input wire logic tiny_unrounded,
  input wire logic is_quad,
  input wire logic is_sqrt,
  input wire logic is_fpop,
  output logic unimpl,
  output logic ieee_trap,
  output logic [4:0] cexc
);
  import fsc_pkg::*;

  // ----------------------------------------
  // exception evaluation
  // ----------------------------------------
  // quad and square-root fpops always unimplemented
  assign unimpl = is_fpop && (is_quad || is_sqrt);

  always_comb begin
    cexc = raw_exc;
    cexc[EXC_UF] = tiny_unrounded && (raw_exc[EXC_NX] || tem[EXC_UF]);
  end

  assign ieee_trap = is_fpop && !unimpl && ((cexc & tem) != 5'h00);

endmodule

/* verilog/fsc_irq.sv */
`timescale 1ns/1ps
module fsc_irq #(
  parameter int W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] event_set,
  input wire logic clr_we,
  input wire logic [W-1:0] clr_data,
  input wire logic mask_we,
  input wire logic [W-1:0] mask_data,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  // ----------------------------------------
  // sticky status, set beats clear
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~(clr_we ? clr_data : '0)) | event_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= '0;
    end else if (mask_we) begin
      mask <= mask_data;
    end
  end

  assign irq = (status & mask) != '0;

  sticky_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (status != '0) && !clr_we |=> (status & $past(status)) == $past(status))
    else $error("status bit lost without clear");

endmodule

/* verilog/fsc_ctl.sv */
`timescale 1ns/1ps
module fsc_ctl
  import fsc_pkg::*;
#(
  parameter logic [2:0] FPU_VER = 3'h0,
  parameter int TAG_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [TAG_W-1:0] issue_tag,
  input wire logic issue_fpop,
  input wire logic issue_fcmp,
  input wire logic issue_quad,
  input wire logic issue_sqrt,
  input wire logic [1:0] issue_cc_sel,
  input wire logic [1:0] issue_cc_val,
  input wire logic [4:0] issue_exc,
  input wire logic issue_tiny_unrounded,
  input wire logic issue_wr_upper,
  input wire logic issue_wr_lower,
  input wire logic ldfsr_valid,
  input wire logic ldfsr_wide,
  input wire logic [63:0] ldfsr_data,
  output logic trap_valid,
  output logic trap_ieee,
  output logic trap_other,
  output logic [TAG_W-1:0] trap_tag,
  input wire logic trap_ack,
  output logic [63:0] fp_state_register,
  output logic [1:0] round_mode,
  output logic upper_half_dirty,
  output logic lower_half_dirty,
  output logic irq
);
  import fsc_pkg::*;

  localparam logic [63:0] VER_FIELD = {44'h0, FPU_VER, 17'h0};
  localparam logic [63:0] STATE_RESET_VAL = STATE_RESET | VER_FIELD;

  // ----------------------------------------
  // trap sequencing
  // ----------------------------------------
  fsc_state_t state;
  fsc_state_t next_state;
  logic issue_take;
  logic ld_take;
  logic ev_unimpl;
  logic ev_ieee;
  logic [4:0] ev_cexc;

  // stall while a trap is outstanding
  assign issue_ready = (state == FSC_RUN);
  assign issue_take = issue_valid && issue_ready;
  assign ld_take = ldfsr_valid && issue_ready;

  fsc_exc_eval u_eval (
    .tem(fp_state_register[TEM_LSB +: 5]),
    .raw_exc(issue_exc),
    .tiny_unrounded(issue_tiny_unrounded),
    .is_quad(issue_quad),
    .is_sqrt(issue_sqrt),
    .is_fpop(issue_fpop),
    .unimpl(ev_unimpl),
    .ieee_trap(ev_ieee),
    .cexc(ev_cexc)
  );

  always_comb begin
    next_state = state;
    case (state)
      FSC_RUN: begin
        if (issue_take && (ev_unimpl || ev_ieee)) begin
          next_state = FSC_TRAP;
        end
      end
      FSC_TRAP: begin
        if (trap_ack) begin
          next_state = FSC_RUN;
        end
      end
      default: begin
        next_state = FSC_RUN;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= FSC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // trap indication stays up until acknowledged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_ieee <= 1'b0;
      trap_other <= 1'b0;
      trap_tag <= '0;
    end else if (state == FSC_RUN) begin
      trap_ieee <= issue_take && ev_ieee;
      trap_other <= issue_take && ev_unimpl;
      trap_tag <= issue_tag;
    end else if (trap_ack) begin
      trap_ieee <= 1'b0;
      trap_other <= 1'b0;
    end
  end

  assign trap_valid = trap_ieee || trap_other;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_events;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  // both halves latched and no response pending
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wbits = w_data & wmask;
    case (aw_addr)
      OFF_STATE_LO, OFF_STATE_HI, OFF_DIRTY, OFF_IRQ_STAT, OFF_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_STATE_LO: rd_word = fp_state_register[31:0];
      OFF_STATE_HI: rd_word = fp_state_register[63:32];
      OFF_DIRTY: rd_word = {30'h0, upper_half_dirty, lower_half_dirty};
      OFF_IRQ_STAT: rd_word = {{(32-IRQ_W){1'b0}}, irq_status};
      OFF_IRQ_MASK: rd_word = {{(32-IRQ_W){1'b0}}, irq_mask};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // state register update
  // ----------------------------------------
  logic [63:0] next_fp_state;
  logic [63:0] sw_mask;

  // order: bus write, then state load, then the issuing instruction
  always_comb begin
    next_fp_state = fp_state_register;
    sw_mask = 64'h0;
    if (wr_fire && (aw_addr == OFF_STATE_LO)) begin
      sw_mask[31:0] = wmask;
    end
    if (wr_fire && (aw_addr == OFF_STATE_HI)) begin
      sw_mask[63:32] = wmask;
    end
    sw_mask = sw_mask & STATE_WR_MASK;
    next_fp_state = (next_fp_state & ~sw_mask) | ({wbits, wbits} & sw_mask);
    if (ld_take) begin
      if (ldfsr_wide) begin
        next_fp_state = (next_fp_state & ~STATE_WR_MASK) | (ldfsr_data & STATE_WR_MASK);
      end else begin
        next_fp_state[31:0] = (next_fp_state[31:0] & ~STATE_WR_MASK[31:0]) | (ldfsr_data[31:0] & STATE_WR_MASK[31:0]);
      end
    end
    if (issue_take && issue_fpop) begin
      if (ev_unimpl) begin
        next_fp_state[FTT_LSB +: 3] = FTT_UNIMPL;
      end else if (ev_ieee) begin
        next_fp_state[FTT_LSB +: 3] = FTT_IEEE;
        next_fp_state[CEXC_LSB +: 5] = ev_cexc;
      end else begin
        next_fp_state[FTT_LSB +: 3] = FTT_NONE;
        next_fp_state[CEXC_LSB +: 5] = ev_cexc;
        next_fp_state[AEXC_LSB +: 5] = next_fp_state[AEXC_LSB +: 5] | ev_cexc;
        if (issue_fcmp) begin
          case (issue_cc_sel)
            2'h0: next_fp_state[CC0_LSB +: 2] = issue_cc_val;
            2'h1: next_fp_state[CC1_LSB +: 2] = issue_cc_val;
            2'h2: next_fp_state[CC2_LSB +: 2] = issue_cc_val;
            default: next_fp_state[CC3_LSB +: 2] = issue_cc_val;
          endcase
        end
      end
    end
    next_fp_state = (next_fp_state & STATE_RD_MASK & ~VER_FIELD) | VER_FIELD;
    next_fp_state[QNE_BIT] = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fp_state_register <= STATE_RESET_VAL;
    end else begin
      fp_state_register <= next_fp_state;
    end
  end

  assign round_mode = fp_state_register[RD_LSB +: 2];

  // ----------------------------------------
  // register-file dirty bits
  // ----------------------------------------
  // set on issue of any writer
  // set even if later nullified; hardware set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_half_dirty <= 1'b0;
      lower_half_dirty <= 1'b0;
    end else begin
      upper_half_dirty <= ((wr_fire && (aw_addr == OFF_DIRTY)) ? wbits[DIRTY_HI_BIT] : upper_half_dirty)
                          || (issue_take && issue_wr_upper);
      lower_half_dirty <= ((wr_fire && (aw_addr == OFF_DIRTY)) ? wbits[DIRTY_LO_BIT] : lower_half_dirty)
                          || (issue_take && issue_wr_lower);
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_IEEE] = issue_take && ev_ieee;
    irq_events[IRQ_OTHER] = issue_take && ev_unimpl;
    irq_events[IRQ_LDFSR] = ld_take;
  end

  fsc_irq #(
    .W(IRQ_W)
  ) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_set(irq_events),
    .clr_we(wr_fire && (aw_addr == OFF_IRQ_STAT)),
    .clr_data(wbits[IRQ_W-1:0]),
    .mask_we(wr_fire && (aw_addr == OFF_IRQ_MASK)),
    .mask_data(wbits[IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence quad_issue_s;
    issue_take && issue_fpop && issue_quad;
  endsequence

  sequence unimpl_trap_s;
    trap_other && !trap_ieee && (fp_state_register[FTT_LSB +: 3] == FTT_UNIMPL);
  endsequence

  ns_bit_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !fp_state_register[NONSTD_BIT] && !s_axi_rdata[NONSTD_BIT])
    else $error("nonstandard bit not zero");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fp_state_register & ~STATE_RD_MASK) == 64'h0 && !fp_state_register[QNE_BIT])
    else $error("reserved state bits set");

  quad_unimpl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    quad_issue_s |=> unimpl_trap_s)
    else $error("quad instruction did not trap unimplemented");

  sqrt_unimpl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    issue_take && issue_fpop && issue_sqrt |=> unimpl_trap_s ##1 (trap_valid || $past(trap_ack)))
    else $error("square root did not trap unimplemented");

  precise_stall_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trap_valid && !trap_ack |=> trap_valid && !issue_ready && $stable(trap_tag))
    else $error("issue allowed while trap outstanding");

  dirty_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    issue_take && issue_wr_upper |=> upper_half_dirty)
    else $error("upper dirty bit not set");

  dirty_lower_a: assert property (@(posedge aclk) disable iff (!aresetn)
    issue_take && issue_wr_lower && ev_unimpl |=> lower_half_dirty && trap_other)
    else $error("lower dirty bit not set on trapped writer");

  ieee_type_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trap_ieee |-> fp_state_register[FTT_LSB +: 3] == FTT_IEEE)
    else $error("ieee trap with wrong trap type");

  version_const_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fp_state_register[VER_LSB +: 3] == FPU_VER)
    else $error("version field changed");

  accrue_exc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    issue_take && issue_fpop && !ev_ieee && !ev_unimpl
    |=> ((fp_state_register[AEXC_LSB +: 5] & $past(ev_cexc)) == $past(ev_cexc))
        && (fp_state_register[CEXC_LSB +: 5] == $past(ev_cexc)))
    else $error("exceptions not accrued");

endmodule

/* verif/fsc_pipe_model.sv */
`timescale 1ns/1ps
module fsc_pipe_model #(
  parameter int ACK_DLY = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [15:0] op,
  input wire logic [7:0] tag,
  input wire logic issue_ready,
  input wire logic trap_valid,
  output logic issue_valid,
  output logic [7:0] issue_tag,
  output logic [15:0] fields,
  output logic trap_ack
);
  logic [15:0] held;
  logic [3:0] cnt;

  // ----------------------------------------
  // issue side
  // ----------------------------------------
  // released fields show the inverse, so a stale copy never looks valid
  assign fields = issue_valid ? held : ~held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      issue_valid <= 1'b0;
      held <= 16'h0000;
      issue_tag <= 8'h00;
    end else if (go) begin
      issue_valid <= 1'b1;
      held <= op;
      issue_tag <= tag;
    end else if (issue_valid && issue_ready) begin
      issue_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // trap acknowledge, slow on purpose
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (trap_ack) begin
      trap_ack <= 1'b0;
    end else if (trap_valid) begin
      if (cnt == 4'(ACK_DLY)) begin
        trap_ack <= 1'b1;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

/* verif/fsc_ctl_tb.sv */
`timescale 1ns/1ps
module fsc_ctl_tb;
  import fsc_pkg::*;
  typedef struct packed {
    logic [15:0] op;
    logic [4:0] tem;
    logic [1:0] rd;
    logic [1:0] trp;
    logic [2:0] ftt;
    logic [4:0] cexc;
    logic [4:0] aexc;
  } fsc_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, issue_tag, trap_tag, tag;
  logic [31:0] s_axi_wdata, s_axi_rdata, exp_lo, exp_hi;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, round_mode, issue_cc_sel, issue_cc_val;
  logic issue_valid, issue_ready, issue_fpop, issue_fcmp, issue_quad, issue_sqrt, issue_tiny_unrounded;
  logic issue_wr_upper, issue_wr_lower, ldfsr_valid, ldfsr_wide, trap_valid, trap_ieee, trap_other;
  logic trap_ack, upper_half_dirty, lower_half_dirty, irq, go, cmp;
  logic [4:0] issue_exc;
  logic [63:0] ldfsr_data, fp_state_register;
  logic [15:0] op, fields;
  int miscompares, checks, s;
  fsc_row_t rows[10];
  fsc_row_t rw;

  assign {issue_cc_val, issue_cc_sel, issue_wr_lower, issue_wr_upper, issue_tiny_unrounded, issue_exc,
    issue_sqrt, issue_quad, issue_fcmp, issue_fpop} = fields;

  fsc_ctl fsc_ctl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .issue_valid,
    .issue_ready, .issue_tag, .issue_fpop, .issue_fcmp, .issue_quad, .issue_sqrt, .issue_cc_sel,
    .issue_cc_val, .issue_exc, .issue_tiny_unrounded, .issue_wr_upper, .issue_wr_lower, .ldfsr_valid,
    .ldfsr_wide, .ldfsr_data, .trap_valid, .trap_ieee, .trap_other, .trap_tag, .trap_ack,
    .fp_state_register, .round_mode, .upper_half_dirty, .lower_half_dirty, .irq);

  fsc_pipe_model fsc_pipe_model_i (.aclk, .aresetn, .go, .op, .tag, .issue_ready, .trap_valid,
    .issue_valid, .issue_tag, .fields, .trap_ack);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task ld_pulse(input logic w, input logic [63:0] d);
    @(posedge aclk);
    ldfsr_valid <= 1'b1;
    ldfsr_wide <= w;
    ldfsr_data <= d;
    @(posedge aclk);
    ldfsr_valid <= 1'b0;
    ldfsr_data <= 64'h0;
    @(negedge aclk);
  endtask

  // ----------------------------------------
  // bus master, ready judged before the edge
  // ----------------------------------------
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ah, wh, bh;
    logic [1:0] r;
    n = 0;
    bh = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 40) begin
        miscompares++;
        end_sim;
      end
    end
    s_axi_bready <= 1'b0;
    chk(64'(r), 64'(er));
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    rh = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 40) begin
        miscompares++;
        end_sim;
      end
    end
    s_axi_rready <= 1'b0;
    chk(64'(d), 64'(e));
    chk(64'(r), 64'(er));
  endtask

  // ----------------------------------------
  // one instruction through the partner
  // ----------------------------------------
  task run(input fsc_row_t x, input logic [7:0] t);
    int n;
    n = 0;
    @(posedge aclk);
    op <= x.op;
    tag <= t;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 40) begin
        miscompares++;
        end_sim;
      end
    end while (issue_valid);
    chk(64'(trap_ieee), 64'(x.trp[1]));
    chk(64'(trap_other), 64'(x.trp[0]));
    if (x.trp != 2'h0) begin
      chk(64'(trap_tag), 64'(t));
      chk(64'(issue_ready), 64'h0);
    end
    while (trap_valid) begin
      @(negedge aclk);
      n++;
      if (n > 40) begin
        miscompares++;
        end_sim;
      end
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, tag, op, s_axi_wdata} = 72'h0;
    s_axi_wstrb = 4'hF;
    {ldfsr_valid, ldfsr_wide, ldfsr_data} = 66'h0;
    miscompares = 0;
    checks = 0;
    exp_hi = 32'h0000_0000;
    // op: val, sel, wr_lower, wr_upper, tiny, exc, sqrt, quad, fcmp, fpop
    rows[0] = '{16'h0811, 5'h00, 2'h0, 2'h0, 3'h0, 5'h01, 5'h01};
    rows[1] = '{16'h0611, 5'h00, 2'h1, 2'h0, 3'h0, 5'h05, 5'h05};
    rows[2] = '{16'h0201, 5'h04, 2'h2, 2'h2, 3'h1, 5'h04, 5'h00};
    rows[3] = '{16'h0101, 5'h10, 2'h3, 2'h2, 3'h1, 5'h10, 5'h00};
    rows[4] = '{16'h0405, 5'h00, 2'h0, 2'h1, 3'h3, 5'h00, 5'h00};
    rows[5] = '{16'h0819, 5'h00, 2'h1, 2'h1, 3'h3, 5'h00, 5'h00};
    rows[6] = '{16'h8003, 5'h00, 2'h2, 2'h0, 3'h0, 5'h00, 5'h00};
    rows[7] = '{16'h7003, 5'h1F, 2'h3, 2'h0, 3'h0, 5'h00, 5'h00};
    rows[8] = '{16'hD003, 5'h00, 2'h0, 2'h0, 3'h0, 5'h00, 5'h00};
    rows[9] = '{16'hE007, 5'h00, 2'h0, 2'h1, 3'h3, 5'h00, 5'h00};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(64'({irq, upper_half_dirty, lower_half_dirty, trap_valid, issue_ready}), 64'h1);
    rd_chk(OFF_STATE_LO, 32'h0000_0000, RESP_OKAY);
    rd_chk(OFF_STATE_HI, 32'h0000_0000, RESP_OKAY);
    rd_chk(8'h40, 32'h0000_0000, RESP_SLVERR);
    axi_wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    for (int i = 0; i < 10; i++) begin
      rw = rows[i];
      axi_wr(OFF_DIRTY, 32'h0000_0000, RESP_OKAY);
      // ones into every read-only and reserved bit of the low word
      axi_wr(OFF_STATE_LO, {rw.rd, 2'h3, rw.tem, 1'b1, 2'h3, 6'h3F, 2'h3, 12'h000}, RESP_OKAY);
      run(rw, 8'(i));
      cmp = rw.op[1] && rw.trp == 2'h0;
      s = int'(rw.op[13:12]);
      if (cmp && s != 0) exp_hi[2*s-2 +: 2] = rw.op[15:14];
      exp_lo = {rw.rd, 2'h0, rw.tem, 6'h00, rw.ftt, 2'h0, (cmp && s == 0) ? rw.op[15:14] : 2'h0, rw.aexc, rw.cexc};
      rd_chk(OFF_STATE_LO, exp_lo, RESP_OKAY);
      rd_chk(OFF_STATE_HI, exp_hi, RESP_OKAY);
      chk(64'(round_mode), 64'(rw.rd));
      chk(64'(upper_half_dirty), 64'(rw.op[10]));
      chk(64'(lower_half_dirty), 64'(rw.op[11]));
    end
    rd_chk(OFF_IRQ_STAT, 32'h0000_0003, RESP_OKAY);
    ld_pulse(1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
    chk(fp_state_register, 64'h0000_003F_CF80_CFFF);
    chk(64'(irq), 64'h0);
    rd_chk(OFF_IRQ_STAT, 32'h0000_0007, RESP_OKAY);
    axi_wr(OFF_IRQ_MASK, 32'h0000_0004, RESP_OKAY);
    @(negedge aclk);
    chk(64'(irq), 64'h1);
    axi_wr(OFF_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
    @(negedge aclk);
    chk(64'(irq), 64'h0);
    rd_chk(OFF_IRQ_STAT, 32'h0000_0003, RESP_OKAY);
    axi_wr(OFF_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    @(negedge aclk);
    chk(64'(irq), 64'h1);
    // only the strobed byte moves; a narrow load keeps the high word
    @(posedge aclk);
    s_axi_wstrb <= 4'h2;
    axi_wr(OFF_STATE_LO, 32'h0000_0000, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd_chk(OFF_STATE_LO, 32'hCF80_C0FF, RESP_OKAY);
    ld_pulse(1'b0, 64'hFFFF_FFFF_0000_0000);
    chk(fp_state_register, 64'h0000_003F_0000_C000);
    // mid-run reset brings every register back
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(fp_state_register, 64'h0);
    chk(64'({irq, upper_half_dirty, lower_half_dirty, trap_valid, issue_ready}), 64'h1);
    rd_chk(OFF_IRQ_STAT, 32'h0000_0000, RESP_OKAY);
    end_sim;
  end
endmodule
